// File: hdl/hhc_pkg.sv
// package of constants for the holdover history control block
package hhc_pkg;
	// ----------------------------------------------------------------
	// register map (byte addresses = index * 4, since printed offsets are not word aligned)
	// ----------------------------------------------------------------
	localparam logic [15:0] HHC_IDX_TIMER_LO = 16'h100a; // averaging timer [7:0]
	localparam logic [15:0] HHC_IDX_TIMER_MID = 16'h100b; // averaging timer [15:8]
	localparam logic [15:0] HHC_IDX_TIMER_HI = 16'h100c; // averaging timer [23:16]
	localparam logic [15:0] HHC_IDX_TIMER_TOP = 16'h100d; // averaging timer [27:24]
	localparam logic [15:0] HHC_IDX_GATING = 16'h100e; // gating control bits
	localparam logic [15:0] HHC_IDX_HOLDOFF = 16'h1010; // hold-off time in ms
	localparam logic [15:0] HHC_IDX_STATUS = 16'h1020; // block status, read only
	// ----------------------------------------------------------------
	// field positions in the gating control register
	// ----------------------------------------------------------------
	localparam int HHC_BIT_SLEW_GATE = 5;
	localparam int HHC_BIT_FREQ_GATE = 4;
	localparam int HHC_BIT_PHASE_GATE = 3;
	localparam int HHC_BIT_QUICK = 2;
	localparam int HHC_BIT_SINGLE = 1;
	localparam int HHC_BIT_PERSIST = 0;
	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [27:0] HHC_RST_TIMER = 28'h000000a;
	localparam logic [5:0] HHC_RST_GATING = 6'h38;
	localparam logic [7:0] HHC_RST_HOLDOFF = 8'h00;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int HHC_CLK_HZ = 20000000; // system clock rate
	localparam int HHC_TICK_MS = 1; // tick period in ms
	localparam int HHC_TICK_CYC = HHC_CLK_HZ / 1000 * HHC_TICK_MS; // cycles per tick
	localparam logic [31:0] HHC_TICK_CYC_W = 32'(HHC_TICK_CYC);
	// ----------------------------------------------------------------
	// history state machine, one-hot
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		HHC_ST_WAIT = 4'h1, // gates not yet satisfied
		HHC_ST_HOLD = 4'h2, // hold-off running
		HHC_ST_ACCUM = 4'h4, // accumulating history
		HHC_ST_HOLDOVER = 4'h8 // loop in holdover
	} hhc_state_t;
endpackage

// File: hdl/hhc_tick.sv
// one-millisecond tick generator
`timescale 1ns/10ps
`default_nettype none
module hhc_tick (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// tick
	output logic tick_out
);
	logic [31:0] cnt_q; // cycle counter

	// free running divider, wraps once per millisecond
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cnt_q <= 32'h0;
		end else if (cnt_q == hhc_pkg::HHC_TICK_CYC_W - 32'h1) begin
			cnt_q <= 32'h0;
		end else begin
			cnt_q <= cnt_q + 32'h1;
		end
	end

	// pulse on the wrap cycle
	assign tick_out = (cnt_q == hhc_pkg::HHC_TICK_CYC_W - 32'h1);
endmodule
`default_nettype wire

// File: hdl/hhc_top.sv
// holdover history control for loop channel zero, with APB register slave
//
// Local design decision: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module hhc_top (
	// clock and reset
	input wire logic CLK_IN,
	input wire logic RST_B_IN,
	// apb slave
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [17:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	// loop state
	input wire logic SLEW_ACTIVE_IN,
	input wire logic FREQ_LOCK_IN,
	input wire logic PHASE_LOCK_IN,
	input wire logic HOLDOVER_IN,
	input wire logic [47:0] TUNING_WORD_IN,
	// history results
	output logic HISTORY_VALID_OUT,
	output logic HISTORY_ACCUM_OUT,
	output logic [47:0] HOLDOVER_WORD_OUT,
	output logic HOLDOVER_WORD_VALID_OUT
);
	// ----------------------------------------------------------------
	// reset synchroniser
	// ----------------------------------------------------------------
	logic rst_meta_q; // first stage, read only by second
	logic rst_b; // released reset

	// async assert, two-flop release
	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			rst_meta_q <= 1'b0;
			rst_b <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_b <= rst_meta_q;
		end
	end

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	// word index from a byte address, used for both read and write decode
	function automatic logic [15:0] word_idx(input logic [17:0] a);
		word_idx = a[17:2];
	endfunction

	// address is mapped when it hits one of our words and is aligned
	function automatic logic is_mapped(input logic [17:0] a);
		logic [15:0] i;
		i = word_idx(a);
		is_mapped = (a[1:0] == 2'h0) &&
			((i >= hhc_pkg::HHC_IDX_TIMER_LO && i <= hhc_pkg::HHC_IDX_GATING) ||
			i == hhc_pkg::HHC_IDX_HOLDOFF || i == hhc_pkg::HHC_IDX_STATUS);
	endfunction

	logic apb_acc; // access phase
	logic apb_wr; // write taking effect
	logic apb_rd; // read taking effect
	logic [15:0] acc_idx; // index under access

	// zero-wait slave: every access completes in its first access cycle
	assign apb_acc = PSEL_IN && PENABLE_IN;
	assign apb_wr = apb_acc && PWRITE_IN && is_mapped(PADDR_IN);
	assign apb_rd = apb_acc && !PWRITE_IN;
	assign acc_idx = word_idx(PADDR_IN);
	assign PREADY_OUT = 1'b1;
	// unmapped or misaligned addresses answer with an error
	assign PSLVERR_OUT = apb_acc && !is_mapped(PADDR_IN);

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	logic [27:0] timer_q; // averaging period in ms
	logic [5:0] gating_q; // gating control bits
	logic [7:0] holdoff_q; // hold-off in ms

	// timer bytes, one word each; a zero period is not guarded here
	always_ff @(posedge CLK_IN or negedge rst_b) begin
		if (!rst_b) begin
			timer_q <= hhc_pkg::HHC_RST_TIMER;
		end else if (apb_wr) begin
			case (acc_idx)
				hhc_pkg::HHC_IDX_TIMER_LO: timer_q[7:0] <= PWDATA_IN[7:0];
				hhc_pkg::HHC_IDX_TIMER_MID: timer_q[15:8] <= PWDATA_IN[7:0];
				hhc_pkg::HHC_IDX_TIMER_HI: timer_q[23:16] <= PWDATA_IN[7:0];
				// only the low nibble is writable; top bits read zero
				hhc_pkg::HHC_IDX_TIMER_TOP: timer_q[27:24] <= PWDATA_IN[3:0];
				default: timer_q <= timer_q;
			endcase
		end
	end

	// gating bits
	always_ff @(posedge CLK_IN or negedge rst_b) begin
		if (!rst_b) begin
			gating_q <= hhc_pkg::HHC_RST_GATING;
		end else if (apb_wr && acc_idx == hhc_pkg::HHC_IDX_GATING) begin
			gating_q <= PWDATA_IN[5:0];
		end
	end

	// hold-off time
	always_ff @(posedge CLK_IN or negedge rst_b) begin
		if (!rst_b) begin
			holdoff_q <= hhc_pkg::HHC_RST_HOLDOFF;
		end else if (apb_wr && acc_idx == hhc_pkg::HHC_IDX_HOLDOFF) begin
			holdoff_q <= PWDATA_IN[7:0];
		end
	end

	// named views of the gating bits
	logic slew_gate;
	logic freq_gate;
	logic phase_gate;
	logic quick_en;
	logic single_en;
	logic persist_en;
	assign slew_gate = gating_q[hhc_pkg::HHC_BIT_SLEW_GATE];
	assign freq_gate = gating_q[hhc_pkg::HHC_BIT_FREQ_GATE];
	assign phase_gate = gating_q[hhc_pkg::HHC_BIT_PHASE_GATE];
	assign quick_en = gating_q[hhc_pkg::HHC_BIT_QUICK];
	assign single_en = gating_q[hhc_pkg::HHC_BIT_SINGLE];
	assign persist_en = gating_q[hhc_pkg::HHC_BIT_PERSIST];

	// ----------------------------------------------------------------
	// millisecond tick
	// ----------------------------------------------------------------
	logic tick; // one-cycle pulse every ms

	// both counters advance on the same tick so they stay in step
	hhc_tick hhc_tick_inst (
		.clk_in(CLK_IN),
		.rst_b_in(rst_b),
		.tick_out(tick)
	);

	// ----------------------------------------------------------------
	// gating and history state machine
	// ----------------------------------------------------------------
	logic gates_ok; // every enabled gate satisfied
	hhc_pkg::hhc_state_t state_q;
	hhc_pkg::hhc_state_t state_d;
	logic [7:0] hold_cnt_q; // hold-off ms elapsed
	logic [27:0] accum_ms_q; // ms of history accumulated
	logic hist_valid_q; // averaged history available
	logic clear_hist; // wipe history this cycle

	// disabled gates are treated as always satisfied
	assign gates_ok = (!slew_gate || !SLEW_ACTIVE_IN) &&
		(!freq_gate || FREQ_LOCK_IN) &&
		(!phase_gate || PHASE_LOCK_IN);

	// next state
	always_comb begin
		state_d = state_q;
		case (state_q)
			hhc_pkg::HHC_ST_WAIT: begin
				if (HOLDOVER_IN) begin
					state_d = hhc_pkg::HHC_ST_HOLDOVER;
				end else if (gates_ok) begin
					// zero hold-off skips the delay entirely
					state_d = (holdoff_q == 8'h00) ? hhc_pkg::HHC_ST_ACCUM :
						hhc_pkg::HHC_ST_HOLD;
				end
			end
			hhc_pkg::HHC_ST_HOLD: begin
				if (HOLDOVER_IN) begin
					state_d = hhc_pkg::HHC_ST_HOLDOVER;
				end else if (!gates_ok) begin
					state_d = hhc_pkg::HHC_ST_WAIT;
				end else if (holdoff_q == 8'h00) begin
					// hold-off cleared while waiting: no delay left
					state_d = hhc_pkg::HHC_ST_ACCUM;
				end else if (tick && hold_cnt_q >= holdoff_q) begin
					// one extra tick, since the first may come at once: never short
					state_d = hhc_pkg::HHC_ST_ACCUM;
				end
			end
			hhc_pkg::HHC_ST_ACCUM: begin
				if (HOLDOVER_IN) begin
					state_d = hhc_pkg::HHC_ST_HOLDOVER;
				end else if (!gates_ok) begin
					// interruption: go back and re-gate
					state_d = hhc_pkg::HHC_ST_WAIT;
				end
			end
			hhc_pkg::HHC_ST_HOLDOVER: begin
				// reference reacquired: gate again before accumulating
				if (!HOLDOVER_IN) begin
					state_d = hhc_pkg::HHC_ST_WAIT;
				end
			end
			default: state_d = hhc_pkg::HHC_ST_WAIT;
		endcase
	end

	// state register
	always_ff @(posedge CLK_IN or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= hhc_pkg::HHC_ST_WAIT;
		end else begin
			state_q <= state_d;
		end
	end

	// hold-off counter, restarts each time the hold state is entered
	always_ff @(posedge CLK_IN or negedge rst_b) begin
		if (!rst_b) begin
			hold_cnt_q <= 8'h00;
		end else if (state_q != hhc_pkg::HHC_ST_HOLD) begin
			hold_cnt_q <= 8'h00;
		end else if (tick && hold_cnt_q != 8'hff) begin
			hold_cnt_q <= hold_cnt_q + 8'h1;
		end
	end

	// ----------------------------------------------------------------
	// history accumulation
	// ----------------------------------------------------------------
	// leaving accumulation for the wait state without persist wipes history
	// leaving holdover to reacquire wipes it too
	assign clear_hist = !persist_en &&
		((state_q == hhc_pkg::HHC_ST_ACCUM && state_d == hhc_pkg::HHC_ST_WAIT) ||
		(state_q == hhc_pkg::HHC_ST_HOLDOVER && state_d == hhc_pkg::HHC_ST_WAIT));

	logic [27:0] avail_ms; // ms needed before history is available
	// quick start needs only a quarter of the period, at least one ms
	assign avail_ms = quick_en ? ((timer_q[27:2] == 26'h0) ? 28'h1 : {2'h0, timer_q[27:2]}) :
		timer_q;

	// accumulated ms, saturating at the full averaging period
	always_ff @(posedge CLK_IN or negedge rst_b) begin
		if (!rst_b) begin
			accum_ms_q <= 28'h0;
		end else if (clear_hist) begin
			accum_ms_q <= 28'h0;
		end else if (state_q == hhc_pkg::HHC_ST_ACCUM && tick && accum_ms_q < timer_q) begin
			accum_ms_q <= accum_ms_q + 28'h1;
		end
	end

	// history becomes valid once enough ms are in
	always_ff @(posedge CLK_IN or negedge rst_b) begin
		if (!rst_b) begin
			hist_valid_q <= 1'b0;
		end else if (clear_hist) begin
			hist_valid_q <= 1'b0;
		end else if (accum_ms_q >= avail_ms && accum_ms_q != 28'h0) begin
			hist_valid_q <= 1'b1;
		end
	end

	// running average over the period: cumulative mean form uses a divider,
	// each step scaled by one over the ms count plus one
	logic [47:0] avg_q; // averaged tuning word
	logic [47:0] last_q; // most recent tuning word
	logic [47:0] avg_step; // correction this tick
	always_comb begin
		avg_step = 48'h0;
		if (accum_ms_q == 28'h0) begin
			avg_step = TUNING_WORD_IN - avg_q;
		end else if (TUNING_WORD_IN >= avg_q) begin
			avg_step = (TUNING_WORD_IN - avg_q) / {20'h0, accum_ms_q + 28'h1};
		end else begin
			avg_step = 48'h0 - ((avg_q - TUNING_WORD_IN) / {20'h0, accum_ms_q + 28'h1});
		end
	end

	// average updates once per ms while accumulating
	always_ff @(posedge CLK_IN or negedge rst_b) begin
		if (!rst_b) begin
			avg_q <= 48'h0;
		end else if (clear_hist) begin
			avg_q <= 48'h0;
		end else if (state_q == hhc_pkg::HHC_ST_ACCUM && tick) begin
			avg_q <= avg_q + avg_step;
		end
	end

	// latest tuning word, frozen in holdover
	always_ff @(posedge CLK_IN or negedge rst_b) begin
		if (!rst_b) begin
			last_q <= 48'h0;
		end else if (state_q != hhc_pkg::HHC_ST_HOLDOVER) begin
			last_q <= TUNING_WORD_IN;
		end
	end

	// ----------------------------------------------------------------
	// holdover word output
	// ----------------------------------------------------------------
	// averaged history wins; single sample is only the fallback, so both
	// options may be on at once
	always_ff @(posedge CLK_IN or negedge rst_b) begin
		if (!rst_b) begin
			HOLDOVER_WORD_OUT <= 48'h0;
			HOLDOVER_WORD_VALID_OUT <= 1'b0;
		end else if (hist_valid_q) begin
			HOLDOVER_WORD_OUT <= avg_q;
			HOLDOVER_WORD_VALID_OUT <= 1'b1;
		end else if (single_en) begin
			HOLDOVER_WORD_OUT <= last_q;
			HOLDOVER_WORD_VALID_OUT <= 1'b1;
		end else begin
			HOLDOVER_WORD_OUT <= 48'h0;
			HOLDOVER_WORD_VALID_OUT <= 1'b0;
		end
	end

	// status flags, registered
	always_ff @(posedge CLK_IN or negedge rst_b) begin
		if (!rst_b) begin
			HISTORY_VALID_OUT <= 1'b0;
			HISTORY_ACCUM_OUT <= 1'b0;
		end else begin
			HISTORY_VALID_OUT <= hist_valid_q;
			HISTORY_ACCUM_OUT <= (state_q == hhc_pkg::HHC_ST_ACCUM);
		end
	end

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	// registered read data, loaded in the setup cycle
	always_ff @(posedge CLK_IN or negedge rst_b) begin
		if (!rst_b) begin
			PRDATA_OUT <= 32'h0;
		end else if (PSEL_IN && !PENABLE_IN && !PWRITE_IN) begin
			case (word_idx(PADDR_IN))
				hhc_pkg::HHC_IDX_TIMER_LO: PRDATA_OUT <= {24'h0, timer_q[7:0]};
				hhc_pkg::HHC_IDX_TIMER_MID: PRDATA_OUT <= {24'h0, timer_q[15:8]};
				hhc_pkg::HHC_IDX_TIMER_HI: PRDATA_OUT <= {24'h0, timer_q[23:16]};
				hhc_pkg::HHC_IDX_TIMER_TOP: PRDATA_OUT <= {28'h0, timer_q[27:24]};
				hhc_pkg::HHC_IDX_GATING: PRDATA_OUT <= {26'h0, gating_q};
				hhc_pkg::HHC_IDX_HOLDOFF: PRDATA_OUT <= {24'h0, holdoff_q};
				hhc_pkg::HHC_IDX_STATUS: PRDATA_OUT <= {state_q, accum_ms_q};
				default: PRDATA_OUT <= 32'h0;
			endcase
		end else if (apb_rd && !is_mapped(PADDR_IN)) begin
			PRDATA_OUT <= 32'h0;
		end
	end
endmodule
`default_nettype wire

// File: dv/hhc_top_chk.sv
// port checker for the holdover history control top
`timescale 1ns/10ps
`default_nettype none
module hhc_chk (
	// clock, reset and apb
	input wire logic CLK_IN,
	input wire logic RST_B_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [17:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	input wire logic PREADY_OUT,
	input wire logic PSLVERR_OUT,
	// loop state and results
	input wire logic SLEW_ACTIVE_IN,
	input wire logic FREQ_LOCK_IN,
	input wire logic PHASE_LOCK_IN,
	input wire logic HOLDOVER_IN,
	input wire logic HISTORY_VALID_OUT,
	input wire logic HISTORY_ACCUM_OUT,
	input wire logic HOLDOVER_WORD_VALID_OUT
);
	// ----------------------------------------------------------------
	// shadow of control registers, fed from completed apb writes
	// ----------------------------------------------------------------
	logic [5:0] gate_q; // gating bits
	logic [7:0] hoff_q; // hold-off in ms
	logic wr_acc; // write completes at this edge
	logic hit; // mapped, aligned address
	logic ok; // every enabled gate satisfied
	assign wr_acc = PSEL_IN & PENABLE_IN & PWRITE_IN;
	assign hit = PADDR_IN[1:0] == 2'h0 && PADDR_IN[17:2] inside {[hhc_pkg::HHC_IDX_TIMER_LO:
		hhc_pkg::HHC_IDX_GATING], hhc_pkg::HHC_IDX_HOLDOFF, hhc_pkg::HHC_IDX_STATUS};
	assign ok = (!gate_q[5] | !SLEW_ACTIVE_IN) & (!gate_q[4] | FREQ_LOCK_IN) &
		(!gate_q[3] | PHASE_LOCK_IN);
	// shadow updates at the same edge the slave takes the write
	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			gate_q <= hhc_pkg::HHC_RST_GATING;
			hoff_q <= hhc_pkg::HHC_RST_HOLDOFF;
		end else if (wr_acc && PADDR_IN[17:2] == hhc_pkg::HHC_IDX_GATING) begin
			gate_q <= PWDATA_IN[5:0];
		end else if (wr_acc && PADDR_IN[17:2] == hhc_pkg::HHC_IDX_HOLDOFF) begin
			hoff_q <= PWDATA_IN[7:0];
		end
	end
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!RST_B_IN);
	AST_READY: assert property (PREADY_OUT)
		else $error("ready dropped");
	AST_ERR_MAP: assert property (PSEL_IN && PENABLE_IN |-> PSLVERR_OUT == !hit)
		else $error("error flag wrong for address");
	AST_ERR_IDLE: assert property (!(PSEL_IN && PENABLE_IN) |-> !PSLVERR_OUT)
		else $error("error flag outside access");
	// the state moves at one edge and the flag follows at the next, so the
	// gate inputs that decided the start are two samples back
	AST_SLEW: assert property (
		$rose(HISTORY_ACCUM_OUT) && gate_q[5] |-> !$past(SLEW_ACTIVE_IN, 2))
		else $error("accumulation began while slewing");
	AST_FREQ: assert property (
		$rose(HISTORY_ACCUM_OUT) && gate_q[4] |-> $past(FREQ_LOCK_IN, 2))
		else $error("accumulation began without frequency lock");
	AST_PHASE: assert property (
		$rose(HISTORY_ACCUM_OUT) && gate_q[3] |-> $past(PHASE_LOCK_IN, 2))
		else $error("accumulation began without phase lock");
	AST_NO_HOLDOFF: assert property (
		(hoff_q == 8'h00 && !HOLDOVER_IN && ok) [*8] |-> HISTORY_ACCUM_OUT)
		else $error("accumulation late with zero hold-off");
	AST_PERSIST: assert property (
		gate_q[0] && HISTORY_VALID_OUT && !wr_acc |=> HISTORY_VALID_OUT)
		else $error("persistent history lost");
	AST_REACQ: assert property (
		!gate_q[0] && $fell(HOLDOVER_IN) |-> ##[1:4] !HISTORY_VALID_OUT)
		else $error("history kept after holdover exit");
	AST_SINGLE: assert property (
		$rose(HOLDOVER_IN) && gate_q[1] && !HISTORY_VALID_OUT |-> ##[1:4] HOLDOVER_WORD_VALID_OUT)
		else $error("no single sample word");
endmodule
bind hhc_top hhc_chk hhc_chk_inst (.CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN), .PSEL_IN(PSEL_IN),
	.PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN),
	.PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT), .SLEW_ACTIVE_IN(SLEW_ACTIVE_IN),
	.FREQ_LOCK_IN(FREQ_LOCK_IN), .PHASE_LOCK_IN(PHASE_LOCK_IN), .HOLDOVER_IN(HOLDOVER_IN),
	.HISTORY_VALID_OUT(HISTORY_VALID_OUT), .HISTORY_ACCUM_OUT(HISTORY_ACCUM_OUT),
	.HOLDOVER_WORD_VALID_OUT(HOLDOVER_WORD_VALID_OUT));
`default_nettype wire

// File: dv/hhc_top_tb_top.sv
// self-checking bench for the holdover history control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; \
	$display("BAD %0t got %h want %h", $time, (a), (b)); end end
`define WAITC(s, v, n) begin for (int k = 0; k < (n) && (s) !== (v); k++) @(posedge clk); \
	`CHK(s, v) end
module hhc_top_tb_top;
	// ----------------------------------------------------------------
	// stimulus and observed signals
	// ----------------------------------------------------------------
	localparam logic [15:0] I_LO = hhc_pkg::HHC_IDX_TIMER_LO;
	localparam logic [15:0] I_TOP = hhc_pkg::HHC_IDX_TIMER_TOP;
	localparam logic [15:0] I_GT = hhc_pkg::HHC_IDX_GATING;
	localparam logic [15:0] I_HO = hhc_pkg::HHC_IDX_HOLDOFF;
	logic clk = 1'b0;
	logic rst_b = 1'b0; // held low from time zero
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [17:0] paddr = 18'h0;
	logic [31:0] pwdata = 32'h0;
	logic slew = 1'b1; // limiter busy until a scenario frees it
	logic freq = 1'b0;
	logic phase = 1'b0;
	logic hold = 1'b0;
	logic [47:0] tw = 48'h123456789abc; // constant word keeps the expected value simple
	logic [31:0] prdata;
	logic pready, pslverr, hv, ha, hwv;
	logic [47:0] hw;
	int mismatches = 0;
	int compares = 0;
	hhc_top hhc_top_inst (.CLK_IN(clk), .RST_B_IN(rst_b), .PSEL_IN(psel), .PENABLE_IN(penable),
		.PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
		.PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .SLEW_ACTIVE_IN(slew), .FREQ_LOCK_IN(freq),
		.PHASE_LOCK_IN(phase), .HOLDOVER_IN(hold), .TUNING_WORD_IN(tw), .HISTORY_VALID_OUT(hv),
		.HISTORY_ACCUM_OUT(ha), .HOLDOVER_WORD_OUT(hw), .HOLDOVER_WORD_VALID_OUT(hwv));
	// 20 MHz clock
	initial begin
		forever #25 clk = ~clk;
	end
	// ----------------------------------------------------------------
	// bus and helper tasks
	// ----------------------------------------------------------------
	task automatic print_verdict;
		if (mismatches == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// one apb transfer; request held until ready is seen, the watchdog ends a hang
	task automatic apb(input logic w, input logic [15:0] i, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {i, 2'b00};
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) begin
			@(posedge clk);
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [15:0] i, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, i, d, r, e);
		`CHK(e, 1'b0)
	endtask
	task automatic rdchk(input logic [15:0] i, input logic [31:0] x, input logic xe);
		logic [31:0] r;
		logic e;
		apb(1'b0, i, 32'h0, r, e);
		`CHK(r, x)
		`CHK(e, xe)
	endtask
	task automatic loop_set(input logic s, input logic f, input logic p);
		slew <= s;
		freq <= f;
		phase <= p;
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	// reset values, field widths, reserved bits, unmapped address
	task automatic t_regs;
		rdchk(I_LO, 32'h0a, 1'b0);
		rdchk(hhc_pkg::HHC_IDX_TIMER_MID, 32'h0, 1'b0);
		rdchk(hhc_pkg::HHC_IDX_TIMER_HI, 32'h0, 1'b0);
		rdchk(I_GT, 32'h38, 1'b0);
		rdchk(I_HO, 32'h0, 1'b0);
		// idle status: waiting state, nothing accumulated
		rdchk(hhc_pkg::HHC_IDX_STATUS, 32'h10000000, 1'b0);
		rdchk(16'h100f, 32'h0, 1'b1);
		wr(I_TOP, 32'hff);
		rdchk(I_TOP, 32'h0f, 1'b0);
		wr(I_TOP, 32'h0);
		wr(I_GT, 32'hff);
		rdchk(I_GT, 32'h3f, 1'b0);
		wr(I_HO, 32'hab);
		rdchk(I_HO, 32'hab, 1'b0);
		wr(I_HO, 32'h0);
	endtask
	// each gate alone holds accumulation; the others are ignored
	task automatic t_gates;
		logic [5:0] m;
		for (int i = 3; i < 6; i++) begin
			m = 6'h1 << i;
			loop_set(1'b1, 1'b0, 1'b0);
			wr(I_GT, {26'h0, m});
			repeat (10) @(posedge clk);
			`CHK(ha, 1'b0)
			loop_set(!m[5], m[4], m[3]);
			`WAITC(ha, 1'b1, 10)
		end
		loop_set(1'b1, 1'b0, 1'b0);
		`WAITC(ha, 1'b0, 10)
		wr(I_GT, 32'h0);
		`WAITC(ha, 1'b1, 10)
	endtask
	// one millisecond of hold-off after the gates open: between 1 and 2 ms
	task automatic t_holdoff;
		loop_set(1'b1, 1'b0, 1'b0);
		wr(I_GT, 32'h38);
		wr(I_HO, 32'h1);
		loop_set(1'b0, 1'b1, 1'b1);
		repeat (19900) @(posedge clk);
		`CHK(ha, 1'b0)
		`WAITC(ha, 1'b1, 20200)
		wr(I_HO, 32'h0);
	endtask
	// single sample before history, then quick start with timer of 4 ms
	task automatic t_quick;
		loop_set(1'b1, 1'b0, 1'b0);
		wr(I_LO, 32'h4);
		wr(I_GT, 32'h3e);
		hold <= 1'b1;
		`WAITC(hwv, 1'b1, 10)
		`CHK(hw, tw)
		hold <= 1'b0;
		loop_set(1'b0, 1'b1, 1'b1);
		`WAITC(ha, 1'b1, 10)
		`WAITC(hv, 1'b1, 20100)
		hold <= 1'b1;
		repeat (5) @(posedge clk);
		hold <= 1'b0;
		`WAITC(hv, 1'b0, 10)
	endtask
	// full 2 ms period, then history kept across interruptions
	task automatic t_persist;
		loop_set(1'b1, 1'b0, 1'b0);
		wr(I_GT, 32'h38);
		wr(I_LO, 32'h2);
		wr(I_GT, 32'h39);
		loop_set(1'b0, 1'b1, 1'b1);
		`WAITC(ha, 1'b1, 10)
		repeat (19000) @(posedge clk);
		`CHK(hv, 1'b0)
		`WAITC(hv, 1'b1, 21100)
		loop_set(1'b1, 1'b0, 1'b0);
		`WAITC(ha, 1'b0, 10)
		repeat (10) @(posedge clk);
		`CHK(hv, 1'b1)
		hold <= 1'b1;
		repeat (5) @(posedge clk);
		hold <= 1'b0;
		repeat (10) @(posedge clk);
		`CHK(hv, 1'b1)
		wr(I_GT, 32'h38);
		hold <= 1'b1;
		repeat (5) @(posedge clk);
		hold <= 1'b0;
		`WAITC(hv, 1'b0, 10)
	endtask
	// ----------------------------------------------------------------
	// main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		t_regs;
		t_gates;
		t_holdoff;
		t_quick;
		t_persist;
		print_verdict;
	end
	// the three ms-scale scenarios need at most about 100k cycles together
	initial begin
		repeat (104000) @(posedge clk);
		mismatches++;
		print_verdict;
	end
endmodule
`default_nettype wire
